/* File: src/ipx_intc.v */
/*
 * Interrupt priority and external interrupt 2/3 controller.
 * Nine sources: ext0, timer0, ext1, timer1, serial, timer2, counter array,
 * ext2, ext3. Each source has a two-bit level, the counter array only 0 or 1;
 * the highest pending enabled request goes to the core, levels at or below
 * the highest one in service are held off until it returns.
 * Assumes: APB master on clock; source requests are same-domain levels;
 * ext_irq2/3 pins are asynchronous; core pulses irq_ack for the granted
 * source and irq_done when its service routine returns.
 */
`include "ipx_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ipx_intc #(
    parameter NSRC = 9
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Internal sources: bit0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 serial,
    // 5 timer2, 6 counter array
    input  wire [6:0]  src_req,
    // External pins, active low
    input  wire        ext_irq2_pin,
    input  wire        ext_irq3_pin,
    // Core side
    input  wire        irq_ack,
    input  wire        irq_done,
    output reg         irq_req,
    output reg  [3:0]  irq_id,
    output reg  [1:0]  irq_level
);

    // ======================================================================
    // Registers and pin synchronisers
    reg  [7:0] prio_low_reg;
    reg  [7:0] prio_high_reg;
    reg  [7:0] ctrl_reg;
    reg  [7:0] top_reg;
    reg  [1:0] sync2_reg;
    reg  [1:0] sync3_reg;
    reg        last2_reg;
    reg        last3_reg;
    // Stack of active levels, bit n set while level n is in service
    reg  [3:0] active_reg;
    reg  [3:0] stack_reg [0:3];
    reg  [1:0] depth_reg;

    wire       pin2 = sync2_reg[1];
    wire       pin3 = sync3_reg[1];

    // ======================================================================
    // Detection of ext2 and ext3
    wire det2 = ctrl_reg[`IPX_EXT2_EDGE_BIT] ? (last2_reg & ~pin2) : ~pin2; // [R10]
    wire det3 = ctrl_reg[`IPX_EXT3_EDGE_BIT] ? (last3_reg & ~pin3) : ~pin3; // [R09]

    // ======================================================================
    // Level per source
    function [1:0] lvl;
        input hi;
        input lo;
        begin
            lvl = {hi, lo};
        end
    endfunction

    reg  [1:0] src_lvl [0:NSRC-1];
    reg  [NSRC-1:0] pend;
    integer i;
    always @* begin
        for (i = 0; i < 6; i = i + 1) begin
            src_lvl[i] = lvl(prio_high_reg[i], prio_low_reg[i]); // [R03] [R04]
        end
        src_lvl[6] = lvl(1'b0, prio_low_reg[`IPX_PRIO_LOW_CA]); // [R02]
        src_lvl[7] = lvl(top_reg[3], ctrl_reg[`IPX_EXT2_PRIO_BIT]); // [R05] [R11]
        src_lvl[8] = lvl(top_reg[7], ctrl_reg[`IPX_EXT3_PRIO_BIT]); // [R05] [R11]
        pend[6:0] = src_req;
        pend[7] = ctrl_reg[`IPX_EXT2_PEND_BIT] & ctrl_reg[`IPX_EXT2_EN_BIT]; // [R07]
        pend[8] = ctrl_reg[`IPX_EXT3_PEND_BIT] & ctrl_reg[`IPX_EXT3_EN_BIT]; // [R06]
    end

    // ======================================================================
    // Arbitration: highest level wins, lowest index breaks ties
    reg  [3:0] win_id;
    reg  [1:0] win_lvl;
    reg        win_any;
    integer j;
    always @* begin
        win_id  = 4'h0;
        win_lvl = 2'h0;
        win_any = 1'b0;
        for (j = NSRC - 1; j >= 0; j = j - 1) begin
            if (pend[j] && (!win_any || src_lvl[j] >= win_lvl)) begin
                win_any = 1'b1;
                win_lvl = src_lvl[j];
                win_id  = j[3:0];
            end
        end
    end

    // Pre-emption: only strictly above every active level
    wire [2:0] cur_lvl = active_reg[3] ? 3'h4 : active_reg[2] ? 3'h3 :
                         active_reg[1] ? 3'h2 : active_reg[0] ? 3'h1 : `IPX_NO_LEVEL;
    wire       grant   = win_any && ({1'b0, win_lvl} + 3'h1 > cur_lvl); // [R12]

    // ======================================================================
    // APB access
    wire       wr_en   = psel & penable & pwrite;
    wire       ack2    = irq_ack && irq_id == 4'h7;
    wire       ack3    = irq_ack && irq_id == 4'h8;
    reg  [7:0] rd_byte;
    reg        rd_hit;
    always @* begin
        rd_hit  = 1'b1;
        rd_byte = `IPX_RST_BYTE;
        case (paddr)
            `IPX_OFS_PRIO_LOW:  rd_byte = {1'b1, prio_low_reg[6:0]}; // [R01]
            `IPX_OFS_PRIO_HIGH: rd_byte = prio_high_reg;
            `IPX_OFS_CTRL:      rd_byte = ctrl_reg;
            `IPX_OFS_TOP:       rd_byte = top_reg;
            `IPX_OFS_STATUS:    rd_byte = {active_reg, 2'h0, depth_reg};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // ======================================================================
    // Sequential logic
    always @(posedge clock) begin
        if (!rst_n) begin
            prio_low_reg  <= `IPX_RST_BYTE;
            prio_high_reg <= `IPX_RST_BYTE;
            ctrl_reg      <= `IPX_RST_BYTE;
            top_reg       <= `IPX_RST_BYTE;
            sync2_reg     <= 2'h3;
            sync3_reg     <= 2'h3;
            last2_reg     <= 1'b1;
            last3_reg     <= 1'b1;
            active_reg    <= 4'h0;
            depth_reg     <= 2'h0;
            pready        <= 1'b0;
            prdata        <= 32'h0;
            pslverr       <= 1'b0;
            irq_req       <= 1'b0;
            irq_id        <= 4'h0;
            irq_level     <= 2'h0;
        end else begin
            sync2_reg <= {sync2_reg[0], ext_irq2_pin};
            sync3_reg <= {sync3_reg[0], ext_irq3_pin};
            last2_reg <= pin2;
            last3_reg <= pin3;
            // APB answers in the second access cycle, one wait state
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~rd_hit;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= {24'h0, rd_byte};
            // Writes land at the edge where the master samples pready high
            if (wr_en & pready) begin
                case (paddr)
                    `IPX_OFS_PRIO_LOW:  prio_low_reg  <= {1'b0, pwdata[6:0]};
                    `IPX_OFS_PRIO_HIGH: prio_high_reg <= pwdata[7:0] & `IPX_HIGH_MASK;
                    `IPX_OFS_TOP:       top_reg       <= pwdata[7:0] & `IPX_TOP_MASK;
                    `IPX_OFS_CTRL: begin
                        ctrl_reg[7:6] <= pwdata[7:6];
                        ctrl_reg[4:2] <= pwdata[4:2];
                        ctrl_reg[0]   <= pwdata[0];
                    end
                    default: ;
                endcase
            end
            // Pending flags: detection wins over service clear
            if (det2)
                ctrl_reg[`IPX_EXT2_PEND_BIT] <= 1'b1; // [R08]
            else if (ack2 || (!ctrl_reg[`IPX_EXT2_EDGE_BIT] && pin2))
                ctrl_reg[`IPX_EXT2_PEND_BIT] <= 1'b0; // [R08]
            if (det3)
                ctrl_reg[`IPX_EXT3_PEND_BIT] <= 1'b1; // [R08]
            else if (ack3 || (!ctrl_reg[`IPX_EXT3_EDGE_BIT] && pin3))
                ctrl_reg[`IPX_EXT3_PEND_BIT] <= 1'b0; // [R08]
            // Core request and service nesting
            irq_req   <= grant & ~irq_ack;
            irq_id    <= win_id;
            irq_level <= win_lvl;
            if (irq_ack && irq_req) begin
                active_reg[irq_level] <= 1'b1; // [R12]
                stack_reg[depth_reg]  <= {2'h0, irq_level};
                depth_reg             <= depth_reg + 2'h1;
            end else if (irq_done && depth_reg != 2'h0) begin
                active_reg[stack_reg[depth_reg - 2'h1][1:0]] <= 1'b0;
                depth_reg <= depth_reg - 2'h1;
            end
        end
    end

endmodule // ipx_intc

`default_nettype wire

/* File: src/ipx_consts.vh */
/*
 * Constants for the interrupt priority and external interrupt 2/3 block:
 * APB byte offsets, field positions, reset values and level codes.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
//
// Functional notes
// [R01] Low priority bit 7 always reads one
// [R02] Bit 6 raises counter array priority
// [R03] Low bits 5..0 raise six sources one level
// [R04] High bits 5..0 give six sources top level
// [R05] Control bits 7,3 raise ext3, ext2
// [R06] Ext3 requests only when its enable set
// [R07] Ext2 requests only when its enable set
// [R08] Pending flags set on detect, cleared on service
// [R09] Bit 4: ext3 falling edge or low level
// [R10] Bit 0: ext2 falling edge or low level
// [R11] Top register bits 7,3 give top level
// [R12] Two bits form level; higher pre-empts lower
`ifndef IPX_CONSTS_VH
`define IPX_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define IPX_OFS_PRIO_LOW   12'h0B8
`define IPX_OFS_PRIO_HIGH  12'h0B4
`define IPX_OFS_CTRL       12'h0C0
`define IPX_OFS_TOP        12'h0C4
`define IPX_OFS_STATUS     12'h0C8

// ==========================================================================
// Field positions in ext_irq23_control and the low priority register
`define IPX_EXT3_PRIO_BIT  7
`define IPX_EXT3_EN_BIT    6
`define IPX_EXT3_PEND_BIT  5
`define IPX_EXT3_EDGE_BIT  4
`define IPX_EXT2_PRIO_BIT  3
`define IPX_EXT2_EN_BIT    2
`define IPX_EXT2_PEND_BIT  1
`define IPX_EXT2_EDGE_BIT  0
`define IPX_PRIO_LOW_CA    6
`define IPX_PRIO_LOW_UNUSED 7

// ==========================================================================
// Reset values, masks and the no-level code
`define IPX_RST_BYTE       8'h00
`define IPX_TOP_MASK       8'h88
`define IPX_HIGH_MASK      8'h3F
`define IPX_NO_LEVEL       3'h0

`endif

/* File: tb/ipx_intc_properties.sv */
/* Port checker for ipx_intc; assumes a write lands when pready is high. */
`timescale 1ns/1ps
`default_nettype none
module ipx_intc_properties (
    // APB and core side
    input wire clock, rst_n, psel, penable, pwrite, pready, irq_ack, irq_done, irq_req,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0] irq_id,
    input wire [1:0] irq_level
);
    // ====
    // Register shadows, indexed by offset bits 4:2, and service depth
    logic [7:0] sh [8];
    logic [2:0] dep;
    logic [1:0] act;
    wire [2:0] sid = irq_id[2:0];
    always_ff @(posedge clock) begin
        dep <= rst_n ? dep + 3'(irq_ack) - 3'(irq_done) : 3'h0;
        if (irq_ack) act <= irq_level;
        if (psel && penable && pready && pwrite) sh[paddr[4:2]] <= pwdata[7:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_lo7; pready && !pwrite && paddr == 12'h0B8 |-> prdata[7]; endproperty
    a_lo7: assert property (p_lo7) else $error("low bit 7 read zero");
    property p_lvl;
        $rose(irq_req) && irq_id < 4'h7 |-> irq_level == {sh[5][sid] && sid != 3'h6, sh[6][sid]};
    endproperty
    a_lvl: assert property (p_lvl) else $error("source level wrong");
    property p_x2lvl; $rose(irq_req) && irq_id == 4'h7 |-> irq_level == {sh[1][3], sh[0][3]}; endproperty
    a_x2lvl: assert property (p_x2lvl) else $error("ext2 level wrong");
    property p_x3lvl; $rose(irq_req) && irq_id == 4'h8 |-> irq_level == {sh[1][7], sh[0][7]}; endproperty
    a_x3lvl: assert property (p_x3lvl) else $error("ext3 level wrong");
    property p_x3en; $rose(irq_req) && irq_id == 4'h8 |-> sh[0][6]; endproperty
    a_x3en: assert property (p_x3en) else $error("ext3 while disabled");
    property p_x2en; $rose(irq_req) && irq_id == 4'h7 |-> sh[0][2]; endproperty
    a_x2en: assert property (p_x2en) else $error("ext2 while disabled");
    property p_ack; irq_ack && irq_req |=> !irq_req; endproperty
    a_ack: assert property (p_ack) else $error("request held after ack");
    property p_pre; $rose(irq_req) && dep == 3'h1 |-> irq_level > act; endproperty
    a_pre: assert property (p_pre) else $error("no pre-emption margin");
endmodule // ipx_intc_properties
bind ipx_intc ipx_intc_properties u_ipx_intc_properties (.clock, .rst_n, .psel, .penable,
    .pwrite, .pready, .irq_ack, .irq_done, .irq_req, .paddr, .pwdata, .prdata, .irq_id,
    .irq_level);
`default_nettype wire

/* File: tb/ipx_core_model.sv */
/* Core model: acks a request at once, returns after svc_len cycles, nests. */
`timescale 1ns/1ps
`default_nettype none
module ipx_core_model (
    // Clock, reset and handshake
    input wire clock, rst_n, irq_req,
    input wire [4:0] svc_len,
    output var logic irq_ack, irq_done
);
    logic [3:0] dep;
    logic [4:0] tmr;
    always @(posedge clock) begin
        irq_done <= 1'b0;
        irq_ack <= rst_n && irq_req && !irq_ack;
        if (!rst_n) dep <= 4'h0;
        else if (irq_ack) {dep, tmr} <= {dep + 4'h1, svc_len};
        else if (dep != 4'h0 && tmr == 5'h00) {irq_done, dep, tmr} <= {1'b1, dep - 4'h1, svc_len};
        else if (dep != 4'h0) tmr <= tmr - 5'h01;
    end
endmodule // ipx_core_model
`default_nettype wire

/* File: tb/tb.sv */
/* Bench for ipx_intc; the core model answers, the bench drives APB, sources and pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic ext_irq2_pin = 1, ext_irq3_pin = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0] lo, hi, v, w;
    logic [6:0] src_req = 0;
    logic [4:0] svc_len = 5'h08;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    wire pready, pslverr, irq_req, irq_ack, irq_done;
    wire [31:0] prdata;
    wire [3:0] irq_id;
    wire [1:0] irq_level;
    ipx_intc u_ipx_intc (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .src_req, .ext_irq2_pin, .ext_irq3_pin, .irq_ack, .irq_done,
        .irq_req, .irq_id, .irq_level);
    ipx_core_model u_ipx_core_model (.clock, .rst_n, .irq_req, .svc_len, .irq_ack, .irq_done);
    // ====
    // Clock, timeout and shared tasks
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) if (++cyc == 2000) begin error_cnt++; print_verdict(); end
    function automatic logic [1:0] lvl(int s); return {hi[s] && s != 6, lo[s]}; endfunction
    task automatic chk(string n, logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin error_cnt++; $display("unexpected %s exp %h seen %h", n, e, s); end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic irq(logic [3:0] id, logic [1:0] l);
        int n = 0;
        while (irq_req !== 1'b1 && n++ < 40) @(posedge clock);
        chk("irq_req", irq_req, 1);
        chk("irq_id", irq_id, id);
        chk("irq_level", irq_level, l);
        while (irq_ack !== 1'b1 && n++ < 80) @(posedge clock);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        v = $urandom(60564);
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        apb(0, 12'h0B8, 0); chk("low", rd, 32'h80);
        apb(0, 12'hFF0, 0); chk("slverr", err, 1);
        lo = $urandom; hi = $urandom;
        apb(1, 12'h0B8, lo); apb(1, 12'h0B4, hi);
        apb(0, 12'h0B8, 0); chk("low", rd, lo | 8'h80);
        apb(0, 12'h0B4, 0); chk("high", rd, hi & 8'h3F);
        for (int i = 0; i < 7; i++) begin
            src_req[i] <= 1'b1;
            irq(4'(i), lvl(i));
            src_req <= 7'h00;
            repeat (14) @(posedge clock);
        end
        ext_irq2_pin <= 1'b0;
        repeat (8) @(posedge clock);
        chk("irq_req", irq_req, 0);
        v = $urandom; w = $urandom & 8'h88;
        apb(1, 12'h0C4, v); apb(1, 12'h0C0, w | 8'h44);
        irq(4'h7, {v[3], w[3]});
        ext_irq2_pin <= 1'b1;
        repeat (14) @(posedge clock);
        apb(0, 12'h0C0, 0); chk("ctl", rd, w | 8'h44);
        apb(1, 12'h0C0, w | 8'h54);
        ext_irq3_pin <= 1'b0;
        irq(4'h8, {v[7], w[7]});
        repeat (14) @(posedge clock);
        apb(0, 12'h0C0, 0); chk("ctl", rd, w | 8'h54);
        ext_irq3_pin <= 1'b1;
        apb(1, 12'h0B8, 0); apb(1, 12'h0B4, 8'h10);
        svc_len <= 5'h1F;
        src_req <= 7'h02;
        irq(4'h1, 2'h0);
        src_req <= 7'h01;
        repeat (6) @(posedge clock);
        chk("irq_req", irq_req, 0);
        src_req <= 7'h10;
        irq(4'h4, 2'h2);
        src_req <= 7'h00;
        repeat (90) @(posedge clock);
        apb(0, 12'h0C8, 0); chk("status", rd, 0);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
